/* File: rtl/lmsc_pkg.sv */
// Shared constants, types and decode helpers for the LED matrix scan controller
package lmsc_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINE_ON_NS    = 32000;
  localparam int LINE_GAP_NS   = 1000;
  localparam int LINE_ON_CYC   = LINE_ON_NS / CLK_PERIOD_NS;
  localparam int LINE_GAP_CYC  = (LINE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 10;
  localparam int PROD_W        = 18;
  localparam int PWM_SHIFT     = 7;

  // ==========================================================================
  // Register map
  localparam logic [7:0] REG_CONFIG    = 8'h00;
  localparam logic [7:0] REG_M1_FIRST  = 8'h01;
  localparam logic [7:0] REG_M1_LAST   = 8'h0B;
  localparam logic [7:0] REG_UPDATE    = 8'h0C;
  localparam logic [7:0] REG_INTENSITY = 8'h0D;
  localparam logic [7:0] REG_M2_FIRST  = 8'h0E;
  localparam logic [7:0] REG_M2_LAST   = 8'h18;
  localparam logic [7:0] REG_BRIGHT    = 8'h19;
  localparam logic [7:0] REG_RESET     = 8'hFF;
  localparam logic [7:0] M2_BASE_IDX   = 8'h0B;
  localparam int         NUM_COLS      = 11;
  localparam int         NUM_ROWS      = 8;
  localparam int         NUM_DATA      = 22;

  // ==========================================================================
  // Reset values and fields
  localparam logic [7:0] CONFIG_RST    = 8'h00;
  localparam logic [7:0] INTENSITY_RST = 8'h00;
  localparam logic [7:0] BRIGHT_RST    = 8'h80;
  localparam logic [7:0] DATA_RST      = 8'h00;
  localparam logic [7:0] INTENSITY_MSK = 8'h7F;
  localparam int CFG_SSD_BIT     = 7;
  localparam int CFG_MSEL_LSB    = 3;
  localparam int CFG_AEN_BIT     = 2;
  localparam int CFG_GEOM_LSB    = 0;
  localparam int INT_AGS_LSB     = 4;
  localparam int INT_CS_LSB      = 0;
  localparam int BRIGHT_FULL_BIT = 7;
  localparam logic [7:0] BRIGHT_FULL_LEVEL = 8'h80;
  localparam logic [4:0] I2C_ADDR_HI       = 5'h18;

  // ==========================================================================
  // Analogue setting codes
  localparam logic [2:0] GAIN_NEG_CODE = 3'h7;
  localparam logic [5:0] GAIN_NEG_DB   = 6'h3A;
  localparam logic [5:0] GAIN_STEP_DB  = 6'h03;
  localparam logic [6:0] CUR_HI_BASE   = 7'h28;
  localparam logic [6:0] CUR_STEP_MA   = 7'h05;
  localparam logic [3:0] CUR_LO_FIRST  = 4'h8;
  localparam logic [3:0] CUR_LO_BIAS   = 4'h7;
  localparam logic [3:0] CUR_UNUSED    = 4'hF;

  typedef enum logic [1:0] {
    MSEL_M1   = 2'b00,
    MSEL_M2   = 2'b01,
    MSEL_RSV  = 2'b10,
    MSEL_BOTH = 2'b11
  } lmsc_msel_type;

  typedef enum logic [1:0] {
    I2C_IDLE = 2'b00,
    I2C_RECV = 2'b01,
    I2C_ACK  = 2'b10,
    I2C_SKIP = 2'b11
  } lmsc_i2c_state_type;

  typedef enum logic [1:0] {
    BYTE_ADDR = 2'b00,
    BYTE_REG  = 2'b01,
    BYTE_DATA = 2'b10
  } lmsc_byte_kind_type;

  typedef enum logic {
    PH_LIT = 1'b0,
    PH_GAP = 1'b1
  } lmsc_phase_type;

  // Column lines used by a geometry code
  function automatic logic [3:0] geom_cols(input logic [1:0] g);
    return 4'h8 + {2'h0, g};
  endfunction

  // Row lines used by a geometry code
  function automatic logic [3:0] geom_rows(input logic [1:0] g);
    return 4'h8 - {2'h0, g};
  endfunction

endpackage

/* File: rtl/lmsc_scan_if.sv */
// Scan control signals shared by core, line timer and pattern builder
`timescale 1ns/1ps
`default_nettype none
interface lmsc_scan_if;
  logic [3:0] m1_lines;
  logic [3:0] m2_lines;
  logic       scan_m1;
  logic       scan_m2;
  logic [7:0] level;
  logic [1:0] geom;
  logic       line_start;
  logic       lit;
  logic       pwm_on;
  logic       on_m2;
  logic [3:0] idx;

  modport core    (output m1_lines, m2_lines, scan_m1, scan_m2, level, geom,
                   input line_start, lit, pwm_on, on_m2, idx);
  modport timer   (input m1_lines, m2_lines, scan_m1, scan_m2, level,
                   output line_start, lit, pwm_on, on_m2, idx);
  modport pattern (input geom, on_m2, idx);
endinterface
`default_nettype wire

/* File: rtl/lmsc_scan_timer.sv */
// Line timer: lit and gap phases, line index and matrix sequencing
`timescale 1ns/1ps
`default_nettype none
module lmsc_scan_timer
  import lmsc_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  lmsc_scan_if.timer sif
);
  import lmsc_pkg::*;

  typedef struct packed {
    lmsc_phase_type   phase;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       idx;
    logic             on_m2;
    logic [7:0]       level;
    logic             start;
  } lmsc_timer_state_type;

  lmsc_timer_state_type st_reg;
  lmsc_timer_state_type st_next;
  logic [3:0]           nxt_idx;
  logic [PROD_W-1:0]    thr;

  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    nxt_idx       = st_reg.idx + 4'h1;
    st_next.cnt   = st_reg.cnt + CNT_W'(1);
    case (st_reg.phase)
      PH_LIT: begin
        if (st_reg.cnt == CNT_W'(LINE_ON_CYC - 1)) begin
          st_next.phase = PH_GAP;
          st_next.cnt   = '0;
        end
      end
      PH_GAP: begin
        if (st_reg.cnt == CNT_W'(LINE_GAP_CYC - 1)) begin
          st_next.phase = PH_LIT;
          st_next.cnt   = '0;
          st_next.start = 1'b1;
          st_next.level = sif.level;
          st_next.idx   = nxt_idx;
          if (!(st_reg.on_m2 ? sif.scan_m2 : sif.scan_m1) ||
              nxt_idx >= (st_reg.on_m2 ? sif.m2_lines : sif.m1_lines)) begin
            st_next.idx   = 4'h0;
            st_next.on_m2 = (sif.scan_m1 && sif.scan_m2) ? !st_reg.on_m2 : sif.scan_m2;
          end
        end
      end
      default: begin
        st_next.phase = PH_GAP;
        st_next.cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Index wraps so the first line after reset is line one
      st_reg <= '{phase: PH_GAP, cnt: '0, idx: 4'hF, on_m2: 1'b0, level: BRIGHT_FULL_LEVEL,
                  start: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // on share of lit time is level/128
  assign thr            = (PROD_W'(st_reg.level) * PROD_W'(LINE_ON_CYC)) >> PWM_SHIFT;
  assign sif.pwm_on     = (st_reg.phase == PH_LIT) && (PROD_W'(st_reg.cnt) < thr);
  assign sif.lit        = (st_reg.phase == PH_LIT);
  assign sif.line_start = st_reg.start;
  assign sif.on_m2      = st_reg.on_m2;
  assign sif.idx        = st_reg.idx;
endmodule
`default_nettype wire

/* File: rtl/lmsc_line_pattern.sv */
// Line pattern builder: drive pattern of one scan line from live data
`timescale 1ns/1ps
`default_nettype none
module lmsc_line_pattern
  import lmsc_pkg::*;
(
  lmsc_scan_if.pattern                    sif,
  input  wire logic [NUM_DATA-1:0][7:0]   data,
  output logic      [NUM_COLS-1:0]        col,
  output logic      [NUM_ROWS-1:0]        row
);
  import lmsc_pkg::*;

  logic [NUM_ROWS-1:0] row_mask;
  logic [NUM_COLS-1:0] col_mask;
  logic [NUM_COLS-1:0] m2_col;

  // three high bits ignored in 5x11
  assign row_mask = 8'hFF >> (4'h8 - geom_rows(sif.geom));
  assign col_mask = 11'h7FF >> (4'hB - geom_cols(sif.geom));

  genvar k;
  generate
    for (k = 0; k < NUM_COLS; k++) begin : g_m2col
      assign m2_col[k] = data[NUM_COLS + k][sif.idx[2:0]];
    end
  endgenerate

  always_comb begin
    col = '0;
    row = '0;
    if (sif.on_m2) begin
      row = (8'h01 << sif.idx) & row_mask;
      col = m2_col & col_mask;
    end else if (sif.idx < 4'hB) begin
      col = (11'h001 << sif.idx) & col_mask;
      row = data[sif.idx] & row_mask;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/lmsc_top.sv */
// LED matrix scan controller: write-only serial port, registers, scan outputs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - data bytes are staged; any write to update commits them to live data
// - intensity holds reserved bit, gain in 6:4, current in 3:0, resets zero
// - gain code 0..6 gives 0 to +18 dB in 3 dB steps, 7 gives -6 dB
// - current code 0..7 gives 40..75 mA, 8..14 gives 5..35 mA
// - brightness top bit set selects full level 128; resets to that
// - brightness top bit clear uses low seven bits as level 0..127
// - any write to reset register restores every register default
// - power-up reset loads every register default, display blank
// - each scanned line stays lit for 32 us
// - a 1 us dark gap separates successive lines
// - dual 8x8 frame scans first matrix columns then second matrix rows
// - 7x9 scans nine columns and ignores each data MSB
// - geometry 11 and select 11 give dual 5x11 operation
// - 5x11 ignores the three high bits of every data byte
// - first matrix uses column cathodes, second uses row cathodes
// - audio enable makes audio drive brightness, current select ignored
// - shutdown leaves all register contents unchanged
// - soft shutdown bit blanks all current sources and line drivers
// - low shutdown pin forces hardware shutdown
// - config holds shutdown 7, select 4:3, audio 2, geometry 1:0
// - select 00 first, 01 second, 11 both; geometry 8x8 to 5x11
// - data registers 01-0B and 0E-18 map columns; bit n is row n+1
// - register pointer steps by one after each acknowledged data byte
module lmsc_top
  import lmsc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                scl,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [1:0]          ad_sel,
  input  wire logic                shutdown_pin_n,
  output logic [NUM_COLS-1:0]      column_lines,
  output logic [NUM_ROWS-1:0]      row_lines,
  output logic                     current_enable,
  output logic                     audio_mod_en,
  output logic signed [5:0]        audio_gain_db,
  output logic [6:0]               row_current_ma
);
  import lmsc_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    lmsc_i2c_state_type          ist;
    lmsc_byte_kind_type          kind;
    logic [7:0]                  shreg;
    logic [3:0]                  bits;
    logic [7:0]                  ptr;
    logic                        scl_d;
    logic                        sda_d;
    logic                        sda_oe;
    logic                        sda_lvl;
    logic [7:0]                  cfg;
    logic [7:0]                  inten;
    logic [7:0]                  bright;
    logic [NUM_DATA-1:0][7:0]    stage;
    logic [NUM_DATA-1:0][7:0]    live;
    logic [NUM_COLS-1:0]         pat_col;
    logic [NUM_ROWS-1:0]         pat_row;
    logic [NUM_COLS-1:0]         col_out;
    logic [NUM_ROWS-1:0]         row_out;
    logic                        cur_en;
    logic                        aud_en;
    logic [5:0]                  gain_db;
    logic [6:0]                  cur_ma;
  } lmsc_top_state_type;

  lmsc_top_state_type    st_reg;
  lmsc_top_state_type    st_next;
  lmsc_scan_if           sif ();
  logic [NUM_COLS-1:0]   cmb_col;
  logic [NUM_ROWS-1:0]   cmb_row;
  logic [NUM_COLS-1:0]   now_col;
  logic [NUM_ROWS-1:0]   now_row;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  i2c_start;
  logic                  i2c_stop;
  logic                  blank;
  logic                  drive;
  logic [7:0]            sub_idx;
  logic [7:0]            byte_in;

  // ==========================================================================
  // Decode helpers
  function automatic logic [5:0] gain_decode(input logic [2:0] code);
    if (code == GAIN_NEG_CODE) begin
      return GAIN_NEG_DB;
    end
    return 6'(GAIN_STEP_DB * {3'h0, code});
  endfunction

  function automatic logic [6:0] current_decode(input logic [3:0] code);
    if (code < CUR_LO_FIRST) begin
      return 7'(CUR_HI_BASE + CUR_STEP_MA * {3'h0, code});
    end else if (code == CUR_UNUSED) begin
      return 7'h00;
    end
    return 7'(CUR_STEP_MA * {3'h0, code - CUR_LO_BIAS});
  endfunction

  function automatic lmsc_top_state_type reg_defaults(input lmsc_top_state_type s);
    lmsc_top_state_type r;
    r        = s;
    r.cfg    = CONFIG_RST;
    r.inten  = INTENSITY_RST;
    r.bright = BRIGHT_RST;
    r.stage  = {NUM_DATA{DATA_RST}};
    r.live   = {NUM_DATA{DATA_RST}};
    return r;
  endfunction

  // ==========================================================================
  // Scan configuration from live registers
  assign sif.geom     = st_reg.cfg[CFG_GEOM_LSB +: 2];
  assign sif.m1_lines = geom_cols(sif.geom);
  assign sif.m2_lines = geom_rows(sif.geom);
  assign sif.scan_m1  = st_reg.cfg[CFG_MSEL_LSB +: 2] != MSEL_M2;
  assign sif.scan_m2  = st_reg.cfg[CFG_MSEL_LSB +: 2] == MSEL_M2 ||
                        st_reg.cfg[CFG_MSEL_LSB +: 2] == MSEL_BOTH;
  assign sif.level    = st_reg.bright[BRIGHT_FULL_BIT] ? BRIGHT_FULL_LEVEL
                                                        : {1'b0, st_reg.bright[6:0]};

  lmsc_scan_timer u_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .sif     (sif)
  );

  lmsc_line_pattern u_pattern (
    .sif  (sif),
    .data (st_reg.live),
    .col  (cmb_col),
    .row  (cmb_row)
  );

  // ==========================================================================
  // Serial bus conditions
  assign scl_rise  = scl && !st_reg.scl_d;
  assign scl_fall  = !scl && st_reg.scl_d;
  assign i2c_start = scl && st_reg.scl_d && st_reg.sda_d && !sda_in;
  assign i2c_stop  = scl && st_reg.scl_d && !st_reg.sda_d && sda_in;
  assign byte_in   = st_reg.shreg;

  // ==========================================================================
  // Output staging
  // soft shutdown blanks drivers
  assign blank   = st_reg.cfg[CFG_SSD_BIT] || !shutdown_pin_n;
  assign drive   = sif.lit && sif.pwm_on && !blank;
  assign now_col = sif.line_start ? cmb_col : st_reg.pat_col;
  assign now_row = sif.line_start ? cmb_row : st_reg.pat_row;

  always_comb begin
    st_next       = st_reg;
    st_next.scl_d = scl;
    st_next.sda_d = sda_in;
    sub_idx       = 8'h00;

    // Serial receiver
    case (st_reg.ist)
      I2C_IDLE: begin
        st_next.sda_oe = 1'b0;
      end
      I2C_RECV: begin
        if (scl_rise) begin
          st_next.shreg = {st_reg.shreg[6:0], sda_in};
          st_next.bits  = st_reg.bits + 4'h1;
        end else if (scl_fall && st_reg.bits == 4'h8) begin
          st_next.bits   = 4'h0;
          st_next.ist    = I2C_ACK;
          st_next.sda_oe = 1'b1;
          case (st_reg.kind)
            BYTE_ADDR: begin
              st_next.kind = BYTE_REG;
              if (byte_in != {I2C_ADDR_HI, ad_sel, 1'b0}) begin
                st_next.ist    = I2C_SKIP;
                st_next.sda_oe = 1'b0;
              end
            end
            BYTE_REG: begin
              st_next.kind = BYTE_DATA;
              st_next.ptr  = byte_in;
            end
            BYTE_DATA: begin
              st_next.ptr = st_reg.ptr + 8'h01;
              if (st_reg.ptr >= REG_M1_FIRST && st_reg.ptr <= REG_M1_LAST) begin
                sub_idx = st_reg.ptr - REG_M1_FIRST;
                st_next.stage[sub_idx[4:0]] = byte_in;
              end else if (st_reg.ptr >= REG_M2_FIRST && st_reg.ptr <= REG_M2_LAST) begin
                sub_idx = st_reg.ptr - REG_M2_FIRST + M2_BASE_IDX;
                st_next.stage[sub_idx[4:0]] = byte_in;
              end
              case (st_reg.ptr)
                REG_CONFIG: begin
                  st_next.cfg = byte_in;
                end
                REG_UPDATE: begin
                  st_next.live = st_reg.stage;
                end
                REG_INTENSITY: begin
                  st_next.inten = byte_in & INTENSITY_MSK;
                end
                REG_BRIGHT: begin
                  st_next.bright = byte_in;
                end
                REG_RESET: begin
                  st_next = reg_defaults(st_next);
                end
                default: begin
                  st_next.ptr = st_reg.ptr + 8'h01;
                end
              endcase
            end
            default: begin
              st_next.ist    = I2C_SKIP;
              st_next.sda_oe = 1'b0;
            end
          endcase
        end
      end
      I2C_ACK: begin
        if (scl_fall) begin
          st_next.sda_oe = 1'b0;
          st_next.ist    = I2C_RECV;
        end
      end
      I2C_SKIP: begin
        st_next.sda_oe = 1'b0;
      end
      default: begin
        st_next.ist    = I2C_IDLE;
        st_next.sda_oe = 1'b0;
      end
    endcase

    if (i2c_start) begin
      st_next.ist    = I2C_RECV;
      st_next.kind   = BYTE_ADDR;
      st_next.bits   = 4'h0;
      st_next.sda_oe = 1'b0;
    end else if (i2c_stop) begin
      st_next.ist    = I2C_IDLE;
      st_next.sda_oe = 1'b0;
    end

    // shutdown alters no register, only drive
    st_next.pat_col = now_col;
    st_next.pat_row = now_row;
    st_next.col_out = drive ? now_col : '0;
    st_next.row_out = drive ? now_row : '0;
    st_next.cur_en  = !blank;

    st_next.aud_en  = st_reg.cfg[CFG_AEN_BIT];
    st_next.gain_db = gain_decode(st_reg.inten[INT_AGS_LSB +: 3]);
    st_next.cur_ma  = st_reg.cfg[CFG_AEN_BIT] ? 7'h00
                                              : current_decode(st_reg.inten[INT_CS_LSB +: 4]);
    st_next.sda_lvl = 1'b0;
  end

  // ==========================================================================
  // Register stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '{ist: I2C_IDLE, kind: BYTE_ADDR, shreg: 8'h00, bits: 4'h0, ptr: 8'h00,
                  scl_d: 1'b1, sda_d: 1'b1, sda_oe: 1'b0, sda_lvl: 1'b0,
                  cfg: CONFIG_RST, inten: INTENSITY_RST, bright: BRIGHT_RST,
                  stage: {NUM_DATA{DATA_RST}}, live: {NUM_DATA{DATA_RST}},
                  pat_col: '0, pat_row: '0, col_out: '0, row_out: '0,
                  cur_en: 1'b0, aud_en: 1'b0, gain_db: 6'h00, cur_ma: 7'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sda_out        = st_reg.sda_lvl;
  assign sda_oe         = st_reg.sda_oe;
  assign column_lines   = st_reg.col_out;
  assign row_lines      = st_reg.row_out;
  assign current_enable = st_reg.cur_en;
  assign audio_mod_en   = st_reg.aud_en;
  assign audio_gain_db  = $signed(st_reg.gain_db);
  assign row_current_ma = st_reg.cur_ma;
endmodule
`default_nettype wire

/* File: bench/lmsc_monitor.sv */
// Port checker for the LED matrix scan controller
`timescale 1ns/1ps
`default_nettype none
module lmsc_monitor
  import lmsc_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire logic                scl,
  input wire logic                sda_oe,
  input wire logic                shutdown_pin_n,
  input wire logic [NUM_COLS-1:0] column_lines,
  input wire logic [NUM_ROWS-1:0] row_lines,
  input wire logic                current_enable,
  input wire logic                audio_mod_en,
  input wire logic signed [5:0]   audio_gain_db,
  input wire logic [6:0]          row_current_ma
);
  logic       act;
  logic [9:0] dark_cnt;
  logic [9:0] lit_cnt;
  assign act = (column_lines != '0) || (row_lines != '0);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Run lengths of lit and dark output
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !current_enable) begin
      dark_cnt <= 10'h3FF;
    end else if (act) begin
      dark_cnt <= 10'h000;
    end else if (dark_cnt != 10'h3FF) begin
      dark_cnt <= dark_cnt + 10'h001;
    end
    lit_cnt <= (sys_rst || !act) ? 10'h000 : lit_cnt + 10'(lit_cnt != 10'h3FF);
  end
  sequence s_blank;
    !current_enable && column_lines == '0 && row_lines == '0;
  endsequence
  // ==========================================================================
  // Properties
  pin_blank_a: assert property (!shutdown_pin_n |=> s_blank)
    else $error("pin shutdown left outputs on");
  line_gap_a: assert property ($rose(act) |-> dark_cnt >= 10'(LINE_GAP_CYC))
    else $error("gap between lines too short");
  line_lit_a: assert property (act |-> lit_cnt < 10'(LINE_ON_CYC))
    else $error("line lit too long");
  line_steady_a: assert property (act && $past(act) |-> $stable(column_lines) && $stable(row_lines))
    else $error("line pattern changed while lit");
  one_line_a: assert property (act |-> $onehot(column_lines) || $onehot(row_lines))
    else $error("more than one cathode line");
  gain_code_a: assert property (audio_gain_db == -6 || (audio_gain_db >= 0 && audio_gain_db <= 18 && audio_gain_db % 3 == 0))
    else $error("illegal gain value");
  audio_cur_a: assert property (audio_mod_en |-> row_current_ma == 7'h00)
    else $error("current shown under audio");
  cur_step_a: assert property (row_current_ma <= 7'h4B && row_current_ma % 5 == 0)
    else $error("illegal current value");
  ack_hold_a: assert property ($fell(sda_oe) |-> !scl && !$past(scl))
    else $error("ack released during clock high");
endmodule
bind lmsc_top lmsc_monitor mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .scl(scl), .sda_oe(sda_oe),
  .shutdown_pin_n(shutdown_pin_n), .column_lines(column_lines), .row_lines(row_lines),
  .current_enable(current_enable), .audio_mod_en(audio_mod_en),
  .audio_gain_db(audio_gain_db), .row_current_ma(row_current_ma));
`default_nettype wire

/* File: bench/lmsc_host_model.sv */
// Host controller model: write-only serial transfers
`timescale 1ns/1ps
`default_nettype none
module lmsc_host_model
(
  input  wire logic clk_sys,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_low
);
  int acks;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    acks = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      tick(4);
      scl = 1'b1;
      tick(4);
      scl = 1'b0;
      tick(2);
    end
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(2);
    acks += int'(sda_oe === 1'b1);
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] b0,
                      input logic [7:0] b1, input int cnt);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
    put_byte(dev);
    put_byte(ptr);
    put_byte(b0);
    if (cnt > 1) begin
      put_byte(b1);
    end
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(8);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the LED matrix scan controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lmsc_pkg::*;
  logic                clk_sys;
  logic                sys_rst;
  logic                scl;
  logic                sda_low;
  logic                sda_oe;
  logic                sda_out;
  logic                shutdown_pin_n;
  logic                current_enable;
  logic                audio_mod_en;
  logic signed [5:0]   audio_gain_db;
  logic [6:0]          row_current_ma;
  logic [NUM_COLS-1:0] column_lines;
  logic [NUM_ROWS-1:0] row_lines;
  logic [7:0]          rows;
  logic [7:0]          lv [3] = '{8'h84, 8'h04, 8'h7F};
  int                  num_errors;
  int                  checked;
  int                  n;
  int                  g;
  wire logic           sda_in = !(sda_low || (sda_oe && !sda_out));
  lmsc_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .ad_sel(2'b00), .shutdown_pin_n(shutdown_pin_n),
    .column_lines(column_lines), .row_lines(row_lines), .current_enable(current_enable),
    .audio_mod_en(audio_mod_en), .audio_gain_db(audio_gain_db),
    .row_current_ma(row_current_ma));
  lmsc_host_model host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_col(input logic [10:0] col);
    int k;
    k = 0;
    while (column_lines !== col) begin
      @(posedge clk_sys);
      #1;
      k++;
      if (k > 30000) begin
        check(24'h0, 24'h1);
        stop_test();
      end
    end
  endtask
  // Rows, lit length and gap of one line; ends at the next line start
  task automatic measure();
    rows = row_lines;
    n = 0;
    g = 0;
    while ({column_lines, row_lines} !== '0 && n < 700) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while ({column_lines, row_lines} === '0 && g < 700) begin
      @(posedge clk_sys);
      #1;
      g++;
    end
    if (n >= 700 || g >= 700) begin
      check(24'h0, 24'h1);
    end
  endtask
  // Rows, lit length and gap of column one
  task automatic line1();
    wait_col(11'h000);
    wait_col(11'h001);
    measure();
  endtask
  initial begin
    sys_rst = 1'b1;
    shutdown_pin_n = 1'b1;
    num_errors = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    line1();
    check({rows, audio_mod_en}, 0);
    check(n, LINE_ON_CYC);
    check(g, LINE_GAP_CYC);
    check({audio_gain_db, row_current_ma}, {6'h00, 7'h28});
    host.xfer(8'hC0, REG_CONFIG, 8'h04, 8'h00, 1);
    check({audio_mod_en, row_current_ma}, {1'b1, 7'h00});
    host.xfer(8'hC0, REG_CONFIG, 8'h00, 8'h00, 1);
    foreach (lv[i]) begin
      host.xfer(8'hC0, REG_BRIGHT, lv[i], 8'h00, 1);
      line1();
      check(n, ((lv[i][7] ? 128 : int'(lv[i][6:0])) * LINE_ON_CYC) >> 7);
    end
    for (int i = 0; i < 16; i++) begin
      host.xfer(8'hC0, REG_INTENSITY, {1'b1, i[2:0], i[3:0]}, 8'h00, 1);
      check(audio_gain_db, (i % 8 == 7) ? -6 : 3 * (i % 8));
      check(row_current_ma, (i < 8) ? 40 + 5 * i : (i == 15) ? 0 : 5 * (i - 7));
    end
    g = host.acks;
    host.xfer(8'hC0, REG_M1_FIRST, 8'hA5, 8'h3C, 2);
    host.xfer(8'hC2, REG_M1_FIRST, 8'hFF, 8'hFF, 2);
    check(host.acks - g, 4);
    line1();
    check(rows, 8'h00);
    host.xfer(8'hC0, REG_UPDATE, 8'h5A, 8'h00, 1);
    line1();
    check(rows, 8'hA5);
    wait_col(11'h002);
    check(row_lines, 8'h3C);
    host.xfer(8'hC0, REG_M1_FIRST, 8'hFF, 8'h00, 1);
    host.xfer(8'hC0, REG_UPDATE, 8'h00, 8'h00, 1);
    host.xfer(8'hC0, REG_CONFIG, 8'h01, 8'h00, 1);
    line1();
    check(rows, 8'h7F);
    wait_col(11'h100);
    measure();
    check(column_lines, 11'h001);
    host.xfer(8'hC0, REG_CONFIG, 8'h1B, 8'h00, 1);
    line1();
    check(rows, 8'h1F);
    wait_col(11'h400);
    measure();
    check({column_lines, row_lines}, {11'h000, 8'h01});
    shutdown_pin_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({current_enable, column_lines, row_lines}, 0);
    shutdown_pin_n = 1'b1;
    host.xfer(8'hC0, REG_CONFIG, 8'h9B, 8'h00, 1);
    check({current_enable, column_lines, row_lines}, 0);
    host.xfer(8'hC0, REG_CONFIG, 8'h1B, 8'h00, 1);
    line1();
    check(rows, 8'h1F);
    host.xfer(8'hC0, REG_RESET, 8'h00, 8'h00, 1);
    line1();
    check({rows, row_current_ma, audio_gain_db}, {8'h00, 7'h28, 6'h00});
    check(n, LINE_ON_CYC);
    host.xfer(8'hC0, REG_M2_FIRST, 8'h01, 8'h00, 1);
    host.xfer(8'hC0, REG_UPDATE, 8'h00, 8'h00, 1);
    host.xfer(8'hC0, REG_CONFIG, 8'h18, 8'h00, 1);
    wait_col(11'h080);
    measure();
    check({column_lines, row_lines}, {11'h001, 8'h01});
    stop_test();
  end
endmodule
`default_nettype wire
